// ---- src/ahp_pkg.sv ----
// shared constants for the converter host port
// Function
// - up to four differential channel pairs
// - input mode chosen per conversion command
// - differential bit set samples pair differentially
// - bipolar bit selects bipolar range
// - default mode: offset zero write starts conversion
// - default acquisition fixed at 1.875 us
// - conversion completes about 10 us later
// - optional end of conversion interrupt request
// - host prepares its interrupt controller first
// - status offset four bit seven shows busy
// - polling host waits busy clear before reading
// - result low byte offset zero, nibble next
// - strap removed selects asynchronous hold mode
// - hold mode: setup at one, start at zero
// - host chooses delay between setup and start
// - unipolar results are straight binary
// - bipolar results are twos complement
// - software may swap differential legs
// - command byte field layout
// - high result nibble in bits three to zero
package ahp_pkg;
  localparam logic [2:0] OFS_CMD      = 3'h0;
  localparam logic [2:0] OFS_SETUP    = 3'h1;
  localparam logic [2:0] OFS_STATUS   = 3'h4;
  localparam int         CHAN_LSB     = 0;
  localparam int         BIP_BIT      = 3;
  localparam int         DIFF_BIT     = 4;
  localparam int         BUSY_BIT     = 7;
  localparam int         CLK_MHZ      = 250;
  localparam int         ACQ_NS       = 1875;
  localparam int         CONV_NS      = 10000;
  localparam int         ACQ_CYC      = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int         CONV_CYC     = (CONV_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] CMD_RST      = 8'h00;
  localparam logic [11:0] RES_RST     = 12'h000;
  localparam logic [11:0] RES_MASK    = 12'hfff;
  localparam logic [7:0] BUSY_MASK    = 8'h80;
  localparam int         HOST_GAP_CYC = 8;
endpackage : ahp_pkg

// ---- src/ahp_if.sv ----
// bus signals between the converter and the host
interface ahp_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  modport dev  (input wr_stb, rd_stb, addr, wdata,
                output rdata, rvalid, irq);
  modport host (output wr_stb, rd_stb, addr, wdata,
                input rdata, rvalid, irq);
endinterface : ahp_if

// ---- src/ahp_dev.sv ----
// converter side: command latch, sequencer and result ports
module ahp_dev
  import ahp_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  ahp_if.dev               BUS,
  input  wire logic        HOLD_MODE_STRAP,
  input  wire logic        IRQ_ENABLE,
  input  wire logic [11:0] SAMPLE_CODE,
  output logic             SAMPLE_REQ,
  output logic [2:0]       CHAN_SEL,
  output logic             DIFF_INPUT_SELECT,
  output logic             BIPOLAR_RANGE_SELECT,
  output logic             CONVERSION_BUSY_FLAG
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10
  } ahp_state_e;

  ahp_state_e  state_r, state_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [11:0] res_r, res_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        irq_r, irq_nxt;
  logic        busy_r, busy_nxt;
  logic        samp_r, samp_nxt;
  logic        strap_m_r, strap_r;
  logic [11:0] code_m_r, code_r;
  logic        irqen_m_r, irqen_r;
  logic        go_cmd, go_setup;

  assign go_cmd   = BUS.wr_stb && (BUS.addr == OFS_CMD);
  assign go_setup = BUS.wr_stb && (BUS.addr == OFS_SETUP);

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    cmd_nxt    = cmd_r;
    res_nxt    = res_r;
    busy_nxt   = busy_r;
    irq_nxt    = 1'b0;
    samp_nxt   = 1'b0;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // strap fitted: direct start; removed: setup then start
        if (go_setup && !strap_r) begin
          cmd_nxt = BUS.wdata;
        end else if (go_cmd) begin
          cmd_nxt  = BUS.wdata;
          busy_nxt = 1'b1;
          if (strap_r) begin
            state_nxt = ST_ACQ;
            cnt_nxt   = 12'(ACQ_CYC - 1);
          end else begin
            // acquisition already given by host between writes
            state_nxt = ST_CONV;
            cnt_nxt   = 12'(CONV_CYC - 1);
          end
        end
      end
      ST_ACQ: begin
        if (cnt_r == 12'h000) begin
          state_nxt = ST_CONV;
          cnt_nxt   = 12'(CONV_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      ST_CONV: begin
        if (cnt_r == 12'h000) begin
          // converter codes passed through: straight or twos compl
          res_nxt   = code_r & RES_MASK;
          samp_nxt  = 1'b1;
          busy_nxt  = 1'b0;
          irq_nxt   = irqen_r;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 12'h001;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // writes during a conversion are ignored; reads always answer
    if (BUS.rd_stb) begin
      rvalid_nxt = 1'b1;
      if (BUS.addr == OFS_CMD) begin
        rdata_nxt = res_r[7:0];
      end else if (BUS.addr == OFS_SETUP) begin
        rdata_nxt = {4'h0, res_r[11:8]};
      end else if (BUS.addr == OFS_STATUS) begin
        rdata_nxt = {busy_r, 7'h00};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 12'h000;
      cmd_r     <= CMD_RST;
      res_r     <= RES_RST;
      busy_r    <= 1'b0;
      irq_r     <= 1'b0;
      samp_r    <= 1'b0;
      rdata_r   <= 8'h00;
      rvalid_r  <= 1'b0;
      strap_m_r <= 1'b1;
      strap_r   <= 1'b1;
      code_m_r  <= 12'h000;
      code_r    <= 12'h000;
      irqen_m_r <= 1'b0;
      irqen_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      cmd_r     <= cmd_nxt;
      res_r     <= res_nxt;
      busy_r    <= busy_nxt;
      irq_r     <= irq_nxt;
      samp_r    <= samp_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      strap_m_r <= HOLD_MODE_STRAP;
      strap_r   <= strap_m_r;
      code_m_r  <= SAMPLE_CODE;
      code_r    <= code_m_r;
      irqen_m_r <= IRQ_ENABLE;
      irqen_r   <= irqen_m_r;
    end
  end

  assign BUS.rdata             = rdata_r;
  assign BUS.rvalid            = rvalid_r;
  assign BUS.irq               = irq_r;
  assign SAMPLE_REQ            = samp_r;
  // odd channel of a pair becomes the plus leg, so legs swap by number
  assign CHAN_SEL              = cmd_r[CHAN_LSB+2:CHAN_LSB];
  assign DIFF_INPUT_SELECT     = cmd_r[DIFF_BIT];
  assign BIPOLAR_RANGE_SELECT  = cmd_r[BIP_BIT];
  assign CONVERSION_BUSY_FLAG  = busy_r;
endmodule : ahp_dev

// ---- src/ahp_host.sv ----
// host side: issues a conversion, waits, reads back 12-bit result
module ahp_host
  import ahp_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  ahp_if.host              BUS,
  input  wire logic        START,
  input  wire logic [7:0]  CMD,
  input  wire logic        HOLD_MODE,
  input  wire logic        USE_IRQ,
  output logic             DONE,
  output logic [11:0]      RESULT,
  output logic             BUSY
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_WAIT  = 3'b010,
    H_POLL  = 3'b011,
    H_LOW   = 3'b100,
    H_HIGH  = 3'b101,
    H_GAP   = 3'b110
  } ahp_hstate_e;

  ahp_hstate_e st_r, st_nxt;
  logic        wr_r, wr_nxt, rd_r, rd_nxt;
  logic [2:0]  addr_r, addr_nxt;
  logic [7:0]  wd_r, wd_nxt, cmd_r, cmd_nxt, lo_r, lo_nxt;
  logic [3:0]  gap_r, gap_nxt;
  logic        done_r, done_nxt, busy_r, busy_nxt, irqen_r, irqen_nxt;
  logic [11:0] res_r, res_nxt;

  always_comb begin
    st_nxt    = st_r;
    wr_nxt    = 1'b0;
    rd_nxt    = 1'b0;
    addr_nxt  = addr_r;
    wd_nxt    = wd_r;
    cmd_nxt   = cmd_r;
    lo_nxt    = lo_r;
    gap_nxt   = gap_r;
    done_nxt  = 1'b0;
    busy_nxt  = busy_r;
    res_nxt   = res_r;
    irqen_nxt = irqen_r;
    case (st_r)
      H_IDLE: begin
        if (START) begin
          cmd_nxt   = CMD;
          busy_nxt  = 1'b1;
          irqen_nxt = USE_IRQ;
          wr_nxt    = 1'b1;
          wd_nxt    = CMD;
          if (HOLD_MODE) begin
            addr_nxt = OFS_SETUP;
            gap_nxt  = 4'(HOST_GAP_CYC);
            st_nxt   = H_SETUP;
          end else begin
            addr_nxt = OFS_CMD;
            st_nxt   = H_WAIT;
          end
        end
      end
      H_SETUP: begin
        // same byte again at offset zero: converter wants identical data
        if (gap_r == 4'h0) begin
          wr_nxt   = 1'b1;
          addr_nxt = OFS_CMD;
          wd_nxt   = cmd_r;
          st_nxt   = H_WAIT;
        end else begin
          gap_nxt = gap_r - 4'h1;
        end
      end
      H_WAIT: begin
        if (!irqen_r) begin
          rd_nxt   = 1'b1;
          addr_nxt = OFS_STATUS;
          st_nxt   = H_POLL;
        end else if (BUS.irq) begin
          rd_nxt   = 1'b1;
          addr_nxt = OFS_CMD;
          st_nxt   = H_LOW;
        end
      end
      H_POLL: begin
        if (BUS.rvalid) begin
          rd_nxt = 1'b1;
          if ((BUS.rdata & BUSY_MASK) != 8'h00) begin
            addr_nxt = OFS_STATUS;
          end else begin
            addr_nxt = OFS_CMD;
            st_nxt   = H_LOW;
          end
        end
      end
      H_LOW: begin
        if (BUS.rvalid) begin
          lo_nxt   = BUS.rdata;
          rd_nxt   = 1'b1;
          addr_nxt = OFS_SETUP;
          st_nxt   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (BUS.rvalid) begin
          res_nxt  = {BUS.rdata[3:0], lo_r} & RES_MASK;
          done_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt   = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      st_r    <= H_IDLE;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      addr_r  <= 3'h0;
      wd_r    <= 8'h00;
      cmd_r   <= 8'h00;
      lo_r    <= 8'h00;
      gap_r   <= 4'h0;
      done_r  <= 1'b0;
      busy_r  <= 1'b0;
      res_r   <= 12'h000;
      irqen_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      addr_r  <= addr_nxt;
      wd_r    <= wd_nxt;
      cmd_r   <= cmd_nxt;
      lo_r    <= lo_nxt;
      gap_r   <= gap_nxt;
      done_r  <= done_nxt;
      busy_r  <= busy_nxt;
      res_r   <= res_nxt;
      irqen_r <= irqen_nxt;
    end
  end

  assign BUS.wr_stb = wr_r;
  assign BUS.rd_stb = rd_r;
  assign BUS.addr   = addr_r;
  assign BUS.wdata  = wd_r;
  assign DONE       = done_r;
  assign RESULT     = res_r;
  assign BUSY       = busy_r;
endmodule : ahp_host

// ---- tb/ahp_monitor.sv ----
// bus checker between the converter and the host
module ahp_monitor
  import ahp_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RST_B,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [2:0] addr,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST = CONV_CYC;
  localparam int SLOW = ACQ_CYC + CONV_CYC;
  logic [12:0] cnt_r;
  logic [12:0] cnt_nxt;
  logic [2:0]  raddr_r;
  logic [2:0]  raddr_nxt;
  // saturates so that idle reads long after a conversion stay legal
  always_comb begin
    cnt_nxt   = (cnt_r == 13'h1fff) ? cnt_r : cnt_r + 13'h1;
    raddr_nxt = rd_stb ? addr : raddr_r;
    if (wr_stb && addr == OFS_CMD) cnt_nxt = 13'h0;
  end
  always_ff @(posedge SYS_CLK) begin
    cnt_r   <= RST_B ? cnt_nxt : 13'h1fff;
    raddr_r <= RST_B ? raddr_nxt : 3'h0;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  read_answer_a: assert property (rd_stb |=> rvalid)
    else $error("read not answered");
  read_cause_a: assert property (rvalid |-> $past(rd_stb))
    else $error("answer without read");
  nibble_zero_a: assert property (rvalid && raddr_r == OFS_SETUP
    |-> rdata[7:4] == 4'h0) else $error("high port upper bits set");
  status_zero_a: assert property (rvalid && raddr_r == OFS_STATUS
    |-> rdata[6:0] == 7'h0) else $error("status unused bits set");
  busy_read_a: assert property (rvalid && raddr_r == OFS_STATUS
    && rdata[BUSY_BIT] |-> cnt_r <= SLOW + 2) else $error("busy too long");
  idle_read_a: assert property (rvalid && raddr_r == OFS_STATUS
    && !rdata[BUSY_BIT] |-> cnt_r >= FAST) else $error("idle too early");
  irq_time_a: assert property (irq |-> (cnt_r >= FAST &&
    cnt_r <= FAST + 2) || (cnt_r >= SLOW && cnt_r <= SLOW + 2))
    else $error("interrupt at wrong time");
  irq_single_a: assert property (irq |=> !irq [*8])
    else $error("interrupt not a single pulse");
endmodule : ahp_monitor

// ---- tb/tb.sv ----
// random conversions through host and converter joined by the bus
module tb
  import ahp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_b, start, hold_mode, use_irq, strap, irq_en;
  logic [11:0] sample_code, result;
  logic [7:0]  cmd;
  logic        done, busy_h, sample_req, diff_sel, bip_sel, busy_flag;
  logic [2:0]  chan_sel;
  int          bad_count, comparisons, cycles;
  logic [11:0] corner [4] = '{12'h000, 12'hfff, 12'h7ff, 12'h800};
  ahp_if bus ();
  ahp_dev i_ahp_dev (.SYS_CLK(sys_clk), .RST_B(rst_b), .BUS(bus),
    .HOLD_MODE_STRAP(strap), .IRQ_ENABLE(irq_en),
    .SAMPLE_CODE(sample_code), .SAMPLE_REQ(sample_req),
    .CHAN_SEL(chan_sel), .DIFF_INPUT_SELECT(diff_sel),
    .BIPOLAR_RANGE_SELECT(bip_sel), .CONVERSION_BUSY_FLAG(busy_flag));
  ahp_host i_ahp_host (.SYS_CLK(sys_clk), .RST_B(rst_b), .BUS(bus),
    .START(start), .CMD(cmd), .HOLD_MODE(hold_mode), .USE_IRQ(use_irq),
    .DONE(done), .RESULT(result), .BUSY(busy_h));
  ahp_monitor i_ahp_monitor (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb), .addr(bus.addr),
    .rdata(bus.rdata), .rvalid(bus.rvalid), .irq(bus.irq));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task finish_test();
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // direct start keeps busy through acquisition; hold start skips it
  function logic [11:0] exp_busy(input logic hold);
    return hold ? 12'(CONV_CYC) : 12'(ACQ_CYC + CONV_CYC);
  endfunction : exp_busy
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic run(input int i);
    int nb;
    int ni;
    int ns;
    int nh;
    int n;
    logic [11:0] code;
    code = (i < 4) ? corner[i] : 12'($urandom);
    @(posedge sys_clk);
    #1;
    cmd = 8'($urandom);
    hold_mode = i[0];
    use_irq = 1'($urandom);
    irq_en = use_irq | 1'($urandom);
    // late runs let host and strap disagree: the strap alone picks the path
    strap = (i < 8) ? ~hold_mode : 1'($urandom);
    sample_code = code;
    // settle the two-stage synchronisers before starting
    repeat (4) @(posedge sys_clk);
    #1 start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    nb = 0;
    ni = 0;
    ns = 0;
    nh = 0;
    n = 0;
    while (n < 4000 && done !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      nb += (busy_flag === 1'b1);
      ni += (bus.irq === 1'b1);
      ns += (sample_req === 1'b1);
      nh += (busy_h === 1'b1);
    end
    check(12'(done), 12'h1);
    check(result, code);
    check(12'(chan_sel), 12'(cmd[2:0]));
    check(12'({diff_sel, bip_sel}),
          12'({cmd[DIFF_BIT], cmd[BIP_BIT]}));
    check(12'(nb), exp_busy(~strap));
    check(12'(ni), 12'(irq_en));
    check(12'(ns), 12'h1);
    // host stays busy until the edge that raises done
    check(12'(nh), 12'(n - 1));
  endtask : run
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    hold_mode = 1'b0;
    use_irq = 1'b0;
    strap = 1'b1;
    irq_en = 1'b0;
    sample_code = 12'h000;
    cmd = 8'h00;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'h20f8c5b8));
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 10; i++) run(i);
    finish_test();
  end
endmodule : tb
